/* File: include/vic_consts.svh */
/*
 Offsets, field positions and reset values of the interrupt control block.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef VIC_CONSTS_SVH
`define VIC_CONSTS_SVH

// ----------------------------------------
// Register indices (word addresses)
// ----------------------------------------
`define VIC_A_STATUS 6'h00
`define VIC_A_CORE 6'h01
`define VIC_A_CTL1 6'h02
`define VIC_A_CTL2 6'h03
`define VIC_A_CTL3 6'h04
`define VIC_A_CTL4 6'h05
`define VIC_A_PEND 6'h06
`define VIC_A_FLAG0 6'h08
`define VIC_A_EN0 6'h0C
`define VIC_A_PRI0 6'h10

// ----------------------------------------
// Sizes and field positions
// ----------------------------------------
`define VIC_NSRC 64
`define VIC_NFREG 4
`define VIC_NPREG 16
`define VIC_FIRST_VEC 8'h08
`define VIC_B_NEST 15
`define VIC_B_GIE 15
`define VIC_B_TMPBLK 14
`define VIC_B_SOFTWARE_TRAP_STATUS 13
`define VIC_B_ALTVT 8
`define VIC_B_LAT 15
`define VIC_B_MSB 3
`define VIC_B_IPL_LO 5

// ----------------------------------------
// Trap vectors and reset values
// ----------------------------------------
`define VIC_V_OSC 8'h00
`define VIC_V_ADDR 8'h01
`define VIC_V_HARD 8'h02
`define VIC_V_STACK 8'h03
`define VIC_V_MATH 8'h04
`define VIC_V_SOFT 8'h06
`define VIC_CTL2_RST 16'h8000
`define VIC_CTL1_MASK 16'hFFDE
`define VIC_CTL2_MASK 16'hE117
`define VIC_CTL3_MASK 16'h0111

`endif

/* File: include/vic_pkg.sv */
/*
 Types shared by the interrupt control block.
 Assumes vic_consts.svh is available on the include path.
*/
package vic_pkg;
    typedef struct packed {
        logic [5:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;

    typedef struct packed {
        logic osc_fail;
        logic addr_err;
        logic stack_err;
        logic div_zero;
        logic bad_shift;
        logic acc_a_ovf;
        logic acc_b_ovf;
        logic acc_a_cat;
        logic acc_b_cat;
        logic sw_hard;
        logic nvm_addr;
        logic loop_ovf;
        logic pll_lost;
    } trap_ev_type;

    typedef struct packed {
        logic valid;
        logic [7:0] vector;
        logic [3:0] level;
        logic alt_table;
    } take_type;
endpackage

/* File: src/vic_top.sv */
/*
 Interrupt and trap control: flags, enables, priorities, trap causes,
 CPU priority level and the pending vector for the core.
 Assumes single-cycle strobes on the register port and one-cycle event pulses.
*/
// Functional notes
// - Each source has a flag set by hardware, cleared only by software.
// - Each source has its own enable bit.
// - Each user source has a 3-bit priority, seven active levels.
// - Pending vector latched at bits 7-0, its priority at bits 11-8.
// - Fields packed in vector order; vector 8 at bit 0.
// - CPU level is core bit 3 joined to status bits 7-5.
// - Status priority bits writable unless nest disable is set.
// - CPU priority msb not writable; when one, user interrupts blocked.
// - CPU level seven blocks every user interrupt.
// - Nest disable bit 15 of control one locks the status priority bits and gates users while a take is pending; nesting still occurs.
// - Global enable resets to one; clear blocks interrupts, not traps.
// - Vector table select bit 8 picks alternate or standard table.
// - External inputs 0,1,2,4 have edge polarity; one means falling.
// - Overflow trap enables per accumulator and catastrophic; cause flags.
// - Math trap flag bit 4 with shift and divide-by-zero causes.
// - Address, stack and oscillator failure trap flags at bits 3,2,1.
// - Soft trap flags: nvm address bit 8, loop stack 4, pll 0.
// - Bit 0 of control four flags a software hard trap.
// - Bit 14 shows temporary block, bit 13 software trap status.
// - Trap vectors 0,1,2,3,4,6; vector 8 is external input 0.
// - New CPU priority encodes 0 to 15 in plain binary.
// - Core bit 15 selects variable or fixed exception latency.
`timescale 1ns/100ps
`include "vic_consts.svh"

module vic_top (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [5:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    input wire logic [63:0] SRC_REQ,
    input wire logic [3:0] EXT_PIN,
    input wire vic_pkg::trap_ev_type TRAP_EV,
    input wire logic TEMP_BLOCK,
    input wire logic TAKE_ACK,
    input wire logic [2:0] RETURN_IPL,
    input wire logic RETURN_STB,
    output vic_pkg::take_type TAKE,
    output logic VAR_LATENCY
);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [15:0] flag_ff [`VIC_NFREG];
    logic [15:0] en_ff [`VIC_NFREG];
    logic [15:0] pri_ff [`VIC_NPREG];
    logic [15:0] ctl1_ff, ctl2_ff, ctl3_ff, ctl4_ff;
    logic [2:0] ipl_ff;
    logic ipl_msb_ff;
    logic var_lat_ff;
    logic [7:0] vec_ff;
    logic [3:0] ilr_ff;
    logic [15:0] rdata_ff;
    logic [2:0] sync_a_ff [4];
    logic [3:0] ext_lvl_ff;
    logic [3:0] ext_ev;
    logic [63:0] hw_set;
    vic_pkg::take_type take_ff;
    vic_pkg::bus_req_type req;

    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    function automatic logic hit(input logic [5:0] a, input logic [5:0] base, input int n);
        hit = (a >= base) && (a < base + 6'(n));
    endfunction

    // ----------------------------------------
    // External edge detection
    // ----------------------------------------
    // Three stages; a change counts once the two later stages agree
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ext
            always_ff @(posedge MCLK) begin
                if (RST) begin
                    sync_a_ff[gi] <= 3'h0;
                    ext_lvl_ff[gi] <= 1'b0;
                end else begin
                    sync_a_ff[gi] <= {sync_a_ff[gi][1:0], EXT_PIN[gi]};
                    if (sync_a_ff[gi][1] == sync_a_ff[gi][2])
                        ext_lvl_ff[gi] <= sync_a_ff[gi][2];
                end
            end
        end
    endgenerate

    logic [3:0] pol;
    logic [3:0] nxt_lvl;
    assign pol = {ctl2_ff[4], ctl2_ff[2], ctl2_ff[1], ctl2_ff[0]};
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            nxt_lvl[i] = (sync_a_ff[i][1] == sync_a_ff[i][2]) ? sync_a_ff[i][2] : ext_lvl_ff[i];
            ext_ev[i] = pol[i] ? (ext_lvl_ff[i] & ~nxt_lvl[i])
                               : (~ext_lvl_ff[i] & nxt_lvl[i]);
        end
    end

    // External 0 at vector 8 (bit 0); the other inputs ride on fixed source slots
    always_comb begin
        hw_set = SRC_REQ;
        hw_set[0] = SRC_REQ[0] | ext_ev[0];
        hw_set[12] = SRC_REQ[12] | ext_ev[1];
        hw_set[21] = SRC_REQ[21] | ext_ev[2];
        hw_set[54] = SRC_REQ[54] | ext_ev[3];
    end

    // ----------------------------------------
    // Flags, enables, priorities
    // ----------------------------------------
    generate
        for (gi = 0; gi < `VIC_NFREG; gi++) begin : g_flag
            always_ff @(posedge MCLK) begin
                if (RST) begin
                    flag_ff[gi] <= 16'h0000;
                    en_ff[gi] <= 16'h0000;
                end else begin
                    // Hardware set wins over a software clear in the same cycle
                    if (req.wr && req.addr == `VIC_A_FLAG0 + 6'(gi))
                        flag_ff[gi] <= req.wdata | hw_set[gi*16 +: 16];
                    else
                        flag_ff[gi] <= flag_ff[gi] | hw_set[gi*16 +: 16];
                    if (req.wr && req.addr == `VIC_A_EN0 + 6'(gi))
                        en_ff[gi] <= req.wdata;
                end
            end
        end
        for (gi = 0; gi < `VIC_NPREG; gi++) begin : g_pri
            always_ff @(posedge MCLK) begin
                if (RST)
                    pri_ff[gi] <= 16'h0000;
                else if (req.wr && req.addr == `VIC_A_PRI0 + 6'(gi))
                    pri_ff[gi] <= req.wdata & 16'h7777;
            end
        end
    endgenerate

    // ----------------------------------------
    // Control and trap registers
    // ----------------------------------------
    function automatic logic [15:0] sticky(input logic [15:0] cur, input logic [15:0] set,
                                           input logic w, input logic [15:0] d,
                                           input logic [15:0] m);
        sticky = ((w ? d : cur) | set) & m;
    endfunction

    logic [15:0] set1, set3, set4;
    logic ovf_a, ovf_b, cat, math;
    assign ovf_a = TRAP_EV.acc_a_ovf & ctl1_ff[10];
    assign ovf_b = TRAP_EV.acc_b_ovf & ctl1_ff[9];
    assign cat = (TRAP_EV.acc_a_cat | TRAP_EV.acc_b_cat) & ctl1_ff[8];
    assign math = ovf_a | ovf_b | cat | TRAP_EV.div_zero | TRAP_EV.bad_shift;
    always_comb begin
        set1 = 16'h0000;
        set1[14] = ovf_a;
        set1[13] = ovf_b;
        set1[12] = TRAP_EV.acc_a_cat & ctl1_ff[8];
        set1[11] = TRAP_EV.acc_b_cat & ctl1_ff[8];
        set1[7] = TRAP_EV.bad_shift;
        set1[6] = TRAP_EV.div_zero;
        set1[4] = math;
        set1[3] = TRAP_EV.addr_err;
        set1[2] = TRAP_EV.stack_err;
        set1[1] = TRAP_EV.osc_fail;
        set3 = {7'h00, TRAP_EV.nvm_addr, 3'h0, TRAP_EV.loop_ovf, 3'h0, TRAP_EV.pll_lost};
        set4 = {15'h0000, TRAP_EV.sw_hard};
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            ctl1_ff <= 16'h0000;
            ctl3_ff <= 16'h0000;
            ctl4_ff <= 16'h0000;
        end else begin
            // Causes stay set until written to zero
            ctl1_ff <= sticky(ctl1_ff, set1, req.wr && req.addr == `VIC_A_CTL1, req.wdata,
                              `VIC_CTL1_MASK);
            ctl3_ff <= sticky(ctl3_ff, set3, req.wr && req.addr == `VIC_A_CTL3, req.wdata,
                              `VIC_CTL3_MASK);
            ctl4_ff <= sticky(ctl4_ff, set4, req.wr && req.addr == `VIC_A_CTL4, req.wdata,
                              16'h0001);
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            ctl2_ff <= `VIC_CTL2_RST;
        else begin
            if (req.wr && req.addr == `VIC_A_CTL2)
                ctl2_ff <= req.wdata & `VIC_CTL2_MASK & ~16'h4000;
            // Mirror keeps tracking even during a write
            ctl2_ff[`VIC_B_TMPBLK] <= TEMP_BLOCK;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            var_lat_ff <= 1'b0;
        else if (req.wr && req.addr == `VIC_A_CORE)
            var_lat_ff <= req.wdata[`VIC_B_LAT];
    end

    // ----------------------------------------
    // CPU priority level
    // ----------------------------------------
    always_ff @(posedge MCLK) begin
        if (RST) begin
            ipl_ff <= 3'h0;
            ipl_msb_ff <= 1'b0;
        end else begin
            if (TAKE_ACK && take_ff.valid) begin
                ipl_ff <= take_ff.level[2:0];
                ipl_msb_ff <= take_ff.level[3];
            end else if (RETURN_STB) begin
                ipl_ff <= RETURN_IPL;
                ipl_msb_ff <= 1'b0;
            end else if (req.wr && req.addr == `VIC_A_STATUS && !ctl1_ff[`VIC_B_NEST])
                ipl_ff <= req.wdata[7:5];
        end
    end

    logic [3:0] cpu_lvl;
    assign cpu_lvl = {ipl_msb_ff, ipl_ff};

    // ----------------------------------------
    // Arbitration
    // ----------------------------------------
    logic [2:0] best_pri;
    logic [7:0] best_vec;
    logic best_ok;
    logic user_ok;
    // Level seven or msb set locks users out; nesting off also blocks users while a take is pending
    assign user_ok = ctl2_ff[`VIC_B_GIE] && !ipl_msb_ff && ipl_ff != 3'h7
                     && !(ctl1_ff[`VIC_B_NEST] && take_ff.valid);
    always_comb begin
        best_pri = 3'h0;
        best_vec = 8'h00;
        best_ok = 1'b0;
        // Downward scan so the lowest vector wins a tie
        for (int s = `VIC_NSRC - 1; s >= 0; s--) begin
            if (flag_ff[s/16][s%16] && en_ff[s/16][s%16]
                && pri_ff[s/4][(s%4)*4 +: 3] != 3'h0
                && pri_ff[s/4][(s%4)*4 +: 3] > ipl_ff
                && pri_ff[s/4][(s%4)*4 +: 3] >= best_pri) begin
                best_pri = pri_ff[s/4][(s%4)*4 +: 3];
                best_vec = `VIC_FIRST_VEC + 8'(s);
                best_ok = 1'b1;
            end
        end
    end

    logic [7:0] trap_vec;
    logic trap_hit;
    always_comb begin
        trap_hit = 1'b1;
        if (ctl1_ff[1]) trap_vec = `VIC_V_OSC;
        else if (ctl1_ff[3]) trap_vec = `VIC_V_ADDR;
        else if (ctl4_ff[0]) trap_vec = `VIC_V_HARD;
        else if (ctl1_ff[2]) trap_vec = `VIC_V_STACK;
        else if (ctl1_ff[4]) trap_vec = `VIC_V_MATH;
        else if (|ctl3_ff) trap_vec = `VIC_V_SOFT;
        else begin
            trap_vec = 8'h00;
            trap_hit = 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            take_ff <= '0;
            vec_ff <= 8'h00;
            ilr_ff <= 4'h0;
        end else begin
            if (TAKE_ACK)
                take_ff.valid <= 1'b0;
            else if (!take_ff.valid && trap_hit && !ipl_msb_ff) begin
                // Traps ignore the global enable
                take_ff <= '{valid: 1'b1, vector: trap_vec, level: 4'h8 + 4'(3'h7 - trap_vec[2:0]),
                             alt_table: ctl2_ff[`VIC_B_ALTVT]};
                vec_ff <= trap_vec;
                ilr_ff <= 4'h8 + 4'(3'h7 - trap_vec[2:0]);
            end else if (!take_ff.valid && best_ok && user_ok) begin
                take_ff <= '{valid: 1'b1, vector: best_vec, level: {1'b0, best_pri},
                             alt_table: ctl2_ff[`VIC_B_ALTVT]};
                vec_ff <= best_vec;
                ilr_ff <= {1'b0, best_pri};
            end
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_ff @(posedge MCLK) begin
        if (RST)
            rdata_ff <= 16'h0000;
        else if (req.rd) begin
            rdata_ff <= 16'h0000;
            if (req.addr == `VIC_A_STATUS) rdata_ff <= {8'h00, ipl_ff, 5'h00};
            else if (req.addr == `VIC_A_CORE)
                rdata_ff <= {var_lat_ff, 11'h000, ipl_msb_ff, 3'h0};
            else if (req.addr == `VIC_A_CTL1) rdata_ff <= ctl1_ff;
            else if (req.addr == `VIC_A_CTL2) rdata_ff <= ctl2_ff;
            else if (req.addr == `VIC_A_CTL3) rdata_ff <= ctl3_ff;
            else if (req.addr == `VIC_A_CTL4) rdata_ff <= ctl4_ff;
            else if (req.addr == `VIC_A_PEND) rdata_ff <= {4'h0, ilr_ff, vec_ff};
            else if (hit(req.addr, `VIC_A_FLAG0, `VIC_NFREG))
                rdata_ff <= flag_ff[2'(req.addr - `VIC_A_FLAG0)];
            else if (hit(req.addr, `VIC_A_EN0, `VIC_NFREG))
                rdata_ff <= en_ff[2'(req.addr - `VIC_A_EN0)];
            else if (hit(req.addr, `VIC_A_PRI0, `VIC_NPREG))
                rdata_ff <= pri_ff[4'(req.addr - `VIC_A_PRI0)];
        end
    end

    assign RDATA = rdata_ff;
    assign TAKE = take_ff;
    assign VAR_LATENCY = var_lat_ff;

endmodule

/* File: testbench/vic_top_assertions.sv */
/*
 Checker for vic_top, attached by bind.
 Assumes one-cycle strobes and one-cycle trap pulses.
*/
`timescale 1ns/100ps
`include "vic_consts.svh"
module vic_checker (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [5:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] RDATA,
    input wire vic_pkg::trap_ev_type TRAP_EV,
    input wire logic TAKE_ACK,
    input wire vic_pkg::take_type TAKE,
    input wire logic VAR_LATENCY
);
    // ----
    // Properties
    // ----
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    a_unmapped_zero: assert property (RD && ADDR == 6'h07 |=> RDATA == 16'h0000)
        else $error("unmapped read not zero");
    a_take_holds: assert property (TAKE.valid && !TAKE_ACK |=> TAKE.valid && $stable(TAKE.vector))
        else $error("pending take dropped before ack");
    a_trap_level: assert property (TAKE.valid && TAKE.vector < 8'h08 |->
        TAKE.level == 4'hF - TAKE.vector[3:0]) else $error("trap level wrong");
    a_user_level: assert property (TAKE.valid && TAKE.vector >= 8'h08 |->
        !TAKE.level[3] && TAKE.level != 4'h0) else $error("user level out of range");
    a_no_reserved: assert property (TAKE.valid |-> TAKE.vector != 8'h05 &&
        TAKE.vector != 8'h07 && TAKE.vector != 8'hFF) else $error("reserved vector taken");
    a_latency_bit: assert property (WR && ADDR == `VIC_A_CORE |=>
        VAR_LATENCY == $past(WDATA[15])) else $error("latency bit not updated");
    a_pend_unused: assert property (RD && ADDR == `VIC_A_PEND |=> RDATA[15:12] == 4'h0)
        else $error("pending upper bits not zero");
    a_ctl2_unused: assert property (RD && ADDR == `VIC_A_CTL2 |=>
        (RDATA & 16'h1EE8) == 16'h0000) else $error("control two unused bits set");
    a_stack_flag: assert property (TRAP_EV.stack_err ##1 !WR ##1
        (RD && ADDR == `VIC_A_CTL1) |=> RDATA[2]) else $error("stack flag not set");
    c_trap_take: cover property (TAKE.valid && TAKE.vector < 8'h08);
    c_user_take: cover property (TAKE.valid && TAKE.vector >= 8'h08);
    c_take_ack: cover property (TAKE.valid && TAKE_ACK);
endmodule

bind vic_top vic_checker u_chk (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .TRAP_EV(TRAP_EV), .TAKE_ACK(TAKE_ACK), .TAKE(TAKE),
    .VAR_LATENCY(VAR_LATENCY));

/* File: testbench/vic_core_model.sv */
/*
 Behavioural core: acknowledges a pending take, later returns.
 Assumes the take stays valid until acknowledged.
*/
`timescale 1ns/100ps
module vic_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire vic_pkg::take_type take,
    input wire logic [3:0] delay,
    output logic ack,
    output logic ret_stb,
    output logic [2:0] ret_ipl
);
    logic [3:0] cnt_ff;
    logic pend_ff, ack_ff, stb_ff;
    // Always returns to level zero; callers must expect that
    assign ret_ipl = 3'h0;
    assign ack = ack_ff;
    assign ret_stb = stb_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= 4'h0;
            pend_ff <= 1'b0;
            ack_ff <= 1'b0;
            stb_ff <= 1'b0;
        end else begin
            ack_ff <= 1'b0;
            stb_ff <= 1'b0;
            if (pend_ff || take.valid) begin
                cnt_ff <= (cnt_ff == delay) ? 4'h0 : cnt_ff + 4'h1;
            end
            if (cnt_ff == delay && pend_ff) begin
                stb_ff <= 1'b1;
                pend_ff <= 1'b0;
            end else if (cnt_ff == delay && take.valid) begin
                ack_ff <= 1'b1;
                pend_ff <= 1'b1;
            end
        end
    end
endmodule

/* File: testbench/vectored_interrupt_control_bench.sv */
/*
 Self-checking bench for vic_top with a core model.
 Assumes vic_top, vic_core_model and the checker compiled first.
*/
`timescale 1ns/100ps
`include "vic_consts.svh"
module vectored_interrupt_control_bench;
    logic mclk, rst, wr_stb, rd_stb, temp_block, take_ack, ret_stb, var_lat;
    logic [5:0] addr;
    logic [15:0] wdata, rdata;
    logic [63:0] src_req;
    logic [3:0] ext_pin, dly;
    logic [2:0] ret_ipl;
    vic_pkg::trap_ev_type trap_ev;
    vic_pkg::take_type take;
    int num_errors, checks;
    vic_top dut (.MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_stb), .RD(rd_stb),
        .RDATA(rdata), .SRC_REQ(src_req), .EXT_PIN(ext_pin), .TRAP_EV(trap_ev),
        .TEMP_BLOCK(temp_block), .TAKE_ACK(take_ack), .RETURN_IPL(ret_ipl),
        .RETURN_STB(ret_stb), .TAKE(take), .VAR_LATENCY(var_lat));
    vic_core_model core (.clk(mclk), .rst(rst), .take(take), .delay(dly), .ack(take_ack),
        .ret_stb(ret_stb), .ret_ipl(ret_ipl));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // ----
    // Tasks
    // ----
    task print_verdict;
        $display("Counts: %0d checks, %0d errors", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task idle(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task bus_wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask
    task rc(input string n, input logic [5:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        chk(n, e, rdata & m);
    endtask
    task rw(input string n, input logic [5:0] a, input logic [15:0] e, input logic [15:0] r);
        bus_wr(a, 16'hFFFF);
        rc(n, a, 16'hFFFF, e);
        bus_wr(a, r);
    endtask
    task pulse(input logic [63:0] v);
        @(posedge mclk);
        src_req <= v;
        @(posedge mclk);
        src_req <= 64'h0;
    endtask
    task ev(input vic_pkg::trap_ev_type e);
        @(posedge mclk);
        trap_ev <= e;
        @(posedge mclk);
        trap_ev <= '0;
    endtask
    task wt(input logic e, input logic [7:0] v, input logic [3:0] l);
        int i;
        i = 0;
        do begin
            @(posedge mclk);
            #1;
            i++;
        end while (i < 24 && take.valid !== 1'b1);
        chk("take_valid", {15'h0, e}, {15'h0, take.valid});
        if (e && take.valid === 1'b1) chk("take", {4'h0, l, v}, {4'h0, take.level, take.vector});
        if (e && take.valid !== 1'b1) print_verdict;
    endtask
    // ----
    // Scenarios
    // ----
    task t_regs;
        rc("pend", `VIC_A_PEND, 16'hFFFF, 16'h0000);
        rc("ctl2", `VIC_A_CTL2, 16'hFFFF, 16'h8000);
        rc("gap", 6'h07, 16'hFFFF, 16'h0000);
        rw("ctl1", `VIC_A_CTL1, 16'hFFDE, 16'h0000);
        rw("ctl2", `VIC_A_CTL2, 16'hA117, 16'h8000);
        rw("ctl3", `VIC_A_CTL3, 16'h0111, 16'h0000);
        rw("ctl4", `VIC_A_CTL4, 16'h0001, 16'h0000);
        @(posedge mclk) temp_block <= 1'b1;
        rc("tmp", `VIC_A_CTL2, 16'h4000, 16'h4000);
        @(posedge mclk) temp_block <= 1'b0;
        idle(40);
        $display("test regs done");
    endtask
    task t_user;
        bus_wr(`VIC_A_EN0, 16'h0001);
        bus_wr(`VIC_A_PRI0, 16'h0005);
        pulse(64'h1);
        wt(1'b1, 8'h08, 4'h5);
        rc("pend", `VIC_A_PEND, 16'hFFFF, 16'h0508);
        rc("flag", `VIC_A_FLAG0, 16'h0001, 16'h0001);
        bus_wr(`VIC_A_FLAG0, 16'h0000);
        rc("flag", `VIC_A_FLAG0, 16'h0001, 16'h0000);
        idle(30);
        // Equal priorities: lower vector first, other one after return
        bus_wr(`VIC_A_EN0, 16'h0007);
        bus_wr(`VIC_A_PRI0, 16'h0665);
        pulse(64'h6);
        wt(1'b1, 8'h09, 4'h6);
        bus_wr(`VIC_A_FLAG0, 16'h0004);
        idle(12);
        wt(1'b1, 8'h0A, 4'h6);
        bus_wr(`VIC_A_FLAG0, 16'h0000);
        bus_wr(`VIC_A_EN0, 16'h0000);
        idle(30);
        $display("test user done");
    endtask
    task t_mask;
        bus_wr(`VIC_A_EN0, 16'h0001);
        bus_wr(`VIC_A_PRI0, 16'h0007);
        bus_wr(`VIC_A_STATUS, 16'h00E0);
        pulse(64'h1);
        wt(1'b0, 8'h00, 4'h0);
        bus_wr(`VIC_A_FLAG0, 16'h0000);
        bus_wr(`VIC_A_STATUS, 16'h0000);
        bus_wr(`VIC_A_CTL2, 16'h0000);
        pulse(64'h1);
        wt(1'b0, 8'h00, 4'h0);
        bus_wr(`VIC_A_FLAG0, 16'h0000);
        @(posedge mclk) dly <= 4'h0;
        ev(13'h1000);
        wt(1'b1, 8'h00, 4'hF);
        bus_wr(`VIC_A_CTL1, 16'h0000);
        bus_wr(`VIC_A_CTL2, 16'h8000);
        bus_wr(`VIC_A_EN0, 16'h0000);
        @(posedge mclk) dly <= 4'hA;
        idle(30);
        $display("test mask done");
    endtask
    task t_nest;
        bus_wr(`VIC_A_CTL1, 16'h8000);
        bus_wr(`VIC_A_STATUS, 16'h00A0);
        rc("ipl", `VIC_A_STATUS, 16'h00E0, 16'h0000);
        bus_wr(`VIC_A_CTL1, 16'h0000);
        bus_wr(`VIC_A_STATUS, 16'h00A0);
        rc("ipl", `VIC_A_STATUS, 16'h00E0, 16'h00A0);
        bus_wr(`VIC_A_EN0, 16'h0001);
        bus_wr(`VIC_A_PRI0, 16'h0005);
        pulse(64'h1);
        wt(1'b0, 8'h00, 4'h0);
        bus_wr(`VIC_A_FLAG0, 16'h0000);
        bus_wr(`VIC_A_STATUS, 16'h0000);
        $display("test nest done");
    endtask
    task t_ext;
        bus_wr(`VIC_A_PRI0, 16'h0003);
        bus_wr(`VIC_A_CTL2, 16'h8001);
        @(posedge mclk) ext_pin <= 4'h1;
        idle(8);
        rc("ext", `VIC_A_FLAG0, 16'h0001, 16'h0000);
        @(posedge mclk) ext_pin <= 4'h0;
        idle(8);
        rc("ext", `VIC_A_FLAG0, 16'h0001, 16'h0001);
        bus_wr(`VIC_A_FLAG0, 16'h0000);
        bus_wr(`VIC_A_CTL2, 16'h8000);
        bus_wr(`VIC_A_EN0, 16'h0000);
        idle(30);
        $display("test ext done");
    endtask
    task t_core_trap;
        bus_wr(`VIC_A_CORE, 16'h8008);
        #1;
        chk("var", 16'h0001, {15'h0, var_lat});
        rc("msb", `VIC_A_CORE, 16'h0008, 16'h0000);
        bus_wr(`VIC_A_CTL2, 16'h8100);
        ev(13'h0400);
        rc("stack", `VIC_A_CTL1, 16'h0004, 16'h0004);
        wt(1'b1, 8'h03, 4'hC);
        chk("alt", 16'h0001, {15'h0, take.alt_table});
        ev(13'h0200);
        rc("math", `VIC_A_CTL1, 16'h0050, 16'h0050);
        bus_wr(`VIC_A_CTL1, 16'h0000);
        bus_wr(`VIC_A_CTL2, 16'h8000);
        idle(30);
        $display("test core_trap done");
    endtask
    initial begin
        rst = 1'b1;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        addr = 6'h00;
        wdata = 16'h0000;
        src_req = 64'h0;
        ext_pin = 4'h0;
        trap_ev = '0;
        temp_block = 1'b0;
        dly = 4'hA;
        num_errors = 0;
        checks = 0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        t_regs;
        t_user;
        t_mask;
        t_nest;
        t_ext;
        t_core_trap;
        print_verdict;
    end
endmodule
